// [port_pullup_enable_regs.sv]
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module port_pullup_enable_regs #(
    parameter int ADDR_WIDTH = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] bankFInput,
    input wire logic [7:0] bankGInput,
    input wire logic [7:0] bankHInput,
    output logic [7:0] bankFPullOn,
    output logic [7:0] bankGPullOn,
    output logic [7:0] bankHPullOn
);
    initial begin
        if (ADDR_WIDTH < 16) begin
            $error("ADDR_WIDTH must hold the 16-bit register offsets");
        end
    end

    logic [7:0] bankF_q;
    logic [7:0] bankG_q;
    logic [7:0] bankH_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [15:0] addr;
    logic setup;
    logic wrHit;

    // Offsets are not word aligned, so the printed offset is an index and byte address = 4x
    function automatic logic [1:0] decode(input logic [15:0] a);
        if (a == 16'((pullup_pkg::BANK_F_OFFSET << 2))) begin
            decode = 2'h1;
        end else if (a == 16'((pullup_pkg::BANK_G_OFFSET << 2))) begin
            decode = 2'h2;
        end else if (a == 16'((pullup_pkg::BANK_H_OFFSET << 2))) begin
            decode = 2'h3;
        end else begin
            decode = 2'h0;
        end
    endfunction

    assign addr = paddr[15:0];
    // Answer is given in the first access cycle; a one-cycle ready pulse
    assign setup = psel && !penable;
    assign wrHit = psel && penable && pready_q && pwrite && pstrb[0];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bankF_q <= pullup_pkg::PULL_RESET;
            bankG_q <= pullup_pkg::PULL_RESET;
            bankH_q <= pullup_pkg::PULL_RESET;
        end else if (wrHit) begin
            unique case (decode(addr))
                2'h1: bankF_q <= pwdata[7:0] & pullup_pkg::BANK_F_MASK;
                2'h2: bankG_q <= pwdata[7:0] & pullup_pkg::BANK_G_MASK;
                2'h3: bankH_q <= pwdata[7:0] & pullup_pkg::BANK_H_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_q <= pullup_pkg::READ_ZERO;
        end else if (setup && !pwrite) begin
            unique case (decode(addr))
                2'h1: prdata_q <= {24'h000000, bankF_q};
                2'h2: prdata_q <= {24'h000000, bankG_q};
                2'h3: prdata_q <= {24'h000000, bankH_q};
                default: prdata_q <= pullup_pkg::READ_ZERO;
            endcase
        end
    end

    // Pullup only where the pin is an input; direction comes from the port logic
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bankFPullOn <= pullup_pkg::PULL_RESET;
            bankGPullOn <= pullup_pkg::PULL_RESET;
            bankHPullOn <= pullup_pkg::PULL_RESET;
        end else begin
            bankFPullOn <= bankF_q & bankFInput;
            bankGPullOn <= bankG_q & bankGInput;
            bankHPullOn <= bankH_q & bankHInput;
        end
    end

    // Unmapped accesses are quietly ignored, so the error flag never rises
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    AST_G_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        bankG_q[7:4] == 4'h0) else $error("G reserved bits not zero");

    AST_H_RESERVED_ZERO: assert property (@(posedge clock) disable iff (!resetn)
        bankH_q[5:3] == 3'h0) else $error("H reserved bits not zero");

    AST_G_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        wrHit && decode(addr) == 2'h2 |=> bankG_q == ($past(pwdata[7:0]) & 8'h0F))
        else $error("G write not stored");

    AST_H_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        wrHit && decode(addr) == 2'h3 |=> bankH_q == ($past(pwdata[7:0]) & 8'hC7))
        else $error("H write not stored");

    AST_F_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        wrHit && decode(addr) == 2'h1 |=> bankF_q == $past(pwdata[7:0]))
        else $error("F write not stored");

    AST_F0_PULL: assert property (@(posedge clock) disable iff (!resetn)
        bankF_q[0] && bankFInput[0] |=> bankFPullOn[0]) else $error("F0 pullup missing");

    AST_OUTPUT_NO_PULL: assert property (@(posedge clock) disable iff (!resetn)
        !bankGInput[0] |=> !bankGPullOn[0]) else $error("Pullup on non-input pin");

    AST_READBACK: assert property (@(posedge clock) disable iff (!resetn)
        setup && !pwrite && decode(addr) == 2'h3 ##1 pready |-> prdata == {24'h0, bankH_q})
        else $error("H readback wrong");

    AST_READY_PULSE: assert property (@(posedge clock) disable iff (!resetn)
        pready |=> !pready) else $error("Ready longer than one cycle");

    AST_F_KEEP: assert property (
        @(posedge clock) disable iff (!resetn)
        !(wrHit && decode(addr) == 2'h1)
        |=> $stable(bankF_q))
        else $error("F register changed without a write");

    AST_G_KEEP: assert property (
        @(posedge clock) disable iff (!resetn)
        !(wrHit && decode(addr) == 2'h2)
        |=> $stable(bankG_q))
        else $error("G register changed without a write");

    AST_H_KEEP: assert property (
        @(posedge clock) disable iff (!resetn)
        !(wrHit && decode(addr) == 2'h3)
        |=> $stable(bankH_q))
        else $error("H register changed without a write");

    AST_STRB_IGNORED: assert property (
        @(posedge clock) disable iff (!resetn)
        psel && penable && pready && pwrite && !pstrb[0]
        |=> $stable(bankF_q) && $stable(bankG_q) && $stable(bankH_q))
        else $error("Write with low byte strobe off took effect");

    AST_UNMAPPED_WRITE: assert property (
        @(posedge clock) disable iff (!resetn)
        wrHit && decode(addr) == 2'h0
        |=> $stable(bankF_q) && $stable(bankG_q) && $stable(bankH_q))
        else $error("Unmapped write changed a register");

    AST_UNMAPPED_READ: assert property (
        @(posedge clock) disable iff (!resetn)
        setup && !pwrite && decode(addr) == 2'h0
        |=> prdata == 32'h0000_0000)
        else $error("Unmapped read not zero");

    AST_F_READBACK: assert property (
        @(posedge clock) disable iff (!resetn)
        setup && !pwrite && decode(addr) == 2'h1
        |=> prdata == {24'h000000, $past(bankF_q)})
        else $error("F readback wrong");

    AST_G_READBACK: assert property (
        @(posedge clock) disable iff (!resetn)
        setup && !pwrite && decode(addr) == 2'h2
        |=> prdata == {24'h000000, $past(bankG_q)})
        else $error("G readback wrong");

    AST_PRDATA_UPPER_ZERO: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |-> prdata[31:8] == 24'h000000)
        else $error("Upper read lanes not zero");

    AST_PRDATA_HOLD: assert property (
        @(posedge clock) disable iff (!resetn)
        !(setup && !pwrite)
        |=> $stable(prdata))
        else $error("Read data moved without a read");

    AST_READY_AFTER_SETUP: assert property (
        @(posedge clock) disable iff (!resetn)
        setup
        |=> pready)
        else $error("No ready in the first access cycle");

    AST_READY_ONLY_AFTER_SETUP: assert property (
        @(posedge clock) disable iff (!resetn)
        pready
        |-> $past(setup))
        else $error("Ready without a setup cycle");

    AST_READ_NO_CHANGE: assert property (
        @(posedge clock) disable iff (!resetn)
        setup && !pwrite
        |=> $stable(bankF_q) && $stable(bankG_q) && $stable(bankH_q))
        else $error("Read changed a register");

    AST_NO_ERROR: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |-> !pslverr)
        else $error("Error response raised");

    AST_F_PULL_OFF: assert property (
        @(posedge clock) disable iff (!resetn)
        !bankF_q[0]
        |=> !bankFPullOn[0])
        else $error("F0 pullup on while disabled");

    AST_F_PULL_FOLLOW: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |=> bankFPullOn == ($past(bankF_q) & $past(bankFInput)))
        else $error("F pullups do not follow enable and direction");

    AST_G_PULL_FOLLOW: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |=> bankGPullOn == ($past(bankG_q) & $past(bankGInput)))
        else $error("G pullups do not follow enable and direction");

    AST_H_PULL_FOLLOW: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |=> bankHPullOn == ($past(bankH_q) & $past(bankHInput)))
        else $error("H pullups do not follow enable and direction");

    AST_G_PULL_RESERVED: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |-> bankGPullOn[7:4] == 4'h0)
        else $error("Pullup on a missing G pin");

    AST_H_PULL_RESERVED: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |-> bankHPullOn[5:3] == 3'h0)
        else $error("Pullup on a missing H pin");

    AST_H_OUTPUT_NO_PULL: assert property (
        @(posedge clock) disable iff (!resetn)
        !bankHInput[7]
        |=> !bankHPullOn[7])
        else $error("H7 pullup on a non-input pin");

    AST_F_OUTPUT_NO_PULL: assert property (
        @(posedge clock) disable iff (!resetn)
        !bankFInput[0]
        |=> !bankFPullOn[0])
        else $error("F0 pullup on a non-input pin");

    AST_G3_OUTPUT_NO_PULL: assert property (
        @(posedge clock) disable iff (!resetn)
        !bankGInput[3]
        |=> !bankGPullOn[3])
        else $error("G3 pullup on a non-input pin");

    AST_G3_PULL_ON: assert property (
        @(posedge clock) disable iff (!resetn)
        bankG_q[3] && bankGInput[3]
        |=> bankGPullOn[3])
        else $error("G3 pullup missing");

    AST_G0_PULL_ON: assert property (
        @(posedge clock) disable iff (!resetn)
        bankG_q[0] && bankGInput[0]
        |=> bankGPullOn[0])
        else $error("G0 pullup missing");

    AST_H6_PULL_ON: assert property (
        @(posedge clock) disable iff (!resetn)
        bankH_q[6] && bankHInput[6]
        |=> bankHPullOn[6])
        else $error("H6 pullup missing");

    AST_H0_PULL_ON: assert property (
        @(posedge clock) disable iff (!resetn)
        bankH_q[0] && bankHInput[0]
        |=> bankHPullOn[0])
        else $error("H0 pullup missing");

    AST_F7_PULL_ON: assert property (
        @(posedge clock) disable iff (!resetn)
        bankF_q[7] && bankFInput[7]
        |=> bankFPullOn[7])
        else $error("F7 pullup missing");
endmodule

// [pullup_pkg.sv]
package pullup_pkg;
    localparam logic [15:0] BANK_F_OFFSET = 16'h30F5;
    localparam logic [15:0] BANK_G_OFFSET = 16'h30F6;
    localparam logic [15:0] BANK_H_OFFSET = 16'h30F7;
    localparam logic [7:0] BANK_F_MASK = 8'hFF;
    localparam logic [7:0] BANK_G_MASK = 8'h0F;
    localparam logic [7:0] BANK_H_MASK = 8'hC7;
    localparam logic [7:0] PULL_RESET = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// [tb.sv]
`timescale 1ns/100ps
module tb;
    logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr;
    logic [7:0] fIn = 8'h00, gIn = 8'h00, hIn = 8'h00, fOn, gOn, hOn;
    logic [7:0] mask [3] = '{pullup_pkg::BANK_F_MASK, pullup_pkg::BANK_G_MASK,
        pullup_pkg::BANK_H_MASK};
    logic [15:0] addr [3] = '{16'hC3D4, 16'hC3D8, 16'hC3DC};
    logic [7:0] regV [3] = '{8'h00, 8'h00, 8'h00};
    logic [31:0] expQ [$];
    logic [31:0] wd;
    int num_errors = 0, checks_done = 0;
    always #2.5 clock = ~clock;
    port_pullup_enable_regs port_pullup_enable_regs_inst (.clock(clock), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bankFInput(fIn), .bankGInput(gIn), .bankHInput(hIn),
        .bankFPullOn(fOn), .bankGPullOn(gOn), .bankHPullOn(hOn));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One idle edge first, so no strobe is assigned twice in a time step
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clock);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        if (!wr) expQ.push_back(e);
        @(posedge clock);
        penable <= 1'b1;
        // Ready is read right after the edge, so the value seen is the one that edge sampled
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    always @(negedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
            check(prdata, expQ.pop_front());
        end
        if (psel && penable && pready === 1'b1) check({31'h0, pslverr}, 32'h0);
    end
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        final_report;
    end
    initial begin
        void'($urandom(85448));
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) apb(1'b0, addr[i], 32'h0, 32'h0);
        $display("test reset values done");
        repeat (6) begin
            for (int i = 0; i < 3; i++) begin
                wd = $urandom;
                regV[i] = wd[7:0] & mask[i];
                apb(1'b1, addr[i], wd, 32'h0);
                apb(1'b0, addr[i], 32'h0, {24'h0, regV[i]});
            end
            fIn <= $urandom; gIn <= $urandom; hIn <= $urandom;
            repeat (3) @(posedge clock);
            check({8'h0, fOn, gOn, hOn}, {8'h0, regV[0] & fIn, regV[1] & gIn, regV[2] & hIn});
        end
        $display("test write, read and pin gating done");
        pstrb <= 4'hE;
        apb(1'b1, addr[1], 32'hFF, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, addr[1], 32'h0, {24'h0, regV[1]});
        apb(1'b1, 16'hC3E0, 32'hFF, 32'h0);
        apb(1'b0, 16'hC3E0, 32'h0, 32'h0);
        $display("test strobe and unmapped done");
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) apb(1'b0, addr[i], 32'h0, 32'h0);
        $display("test mid-run reset done");
        repeat (2) @(posedge clock);
        final_report;
    end
endmodule
